// File: abmh_pkg.sv
// package: constants for the alternate bus master handover block
package abmh_pkg;
  // clock rate and handover timing in memory clock periods
  localparam int unsigned CLK_HZ          = 20_000_000;
  localparam logic [2:0]  GNT_TRISTATE_AT = 3'h1;
  localparam logic [2:0]  GNT_GRANT_AT    = 3'h2;
  localparam logic [2:0]  GNT_CKE_AT      = 3'h4;
  localparam logic [2:0]  REL_GRANT_AT    = 3'h1;
  localparam logic [2:0]  REL_DRIVE_AT    = 3'h3;
  localparam logic [2:0]  REL_CKE_AT      = 3'h4;
  // burst length codes for the mode register command
  localparam logic [2:0]  BURST_NORMAL    = 3'h4;
  localparam logic [2:0]  BURST_LEGACY    = 3'h1;
  // only partition zero is offered to the outside master
  localparam logic [1:0]  SHARED_PART     = 2'h0;
  // sdram memory command codes toward the controller
  typedef enum logic [1:0]
  {
    ABMH_CMD_NONE    = 2'h0,
    ABMH_CMD_REFRESH = 2'h1,
    ABMH_CMD_MODE    = 2'h2
  } abmh_cmd_t;
  // handover states, gray along the usual path
  typedef enum logic [3:0]
  {
    ABMH_OWNED    = 4'h0,
    ABMH_DRAIN    = 4'h1,
    ABMH_G_REF    = 4'h3,
    ABMH_G_MRS    = 4'h2,
    ABMH_G_SEQ    = 4'h6,
    ABMH_LENT     = 4'h7,
    ABMH_R_SEQ    = 4'h5,
    ABMH_R_REF    = 4'h4,
    ABMH_R_MRS    = 4'hC
  } abmh_state_t;
endpackage

// File: abmh_sync.sv
// two-flop synchroniser for a level from outside the clock domain
`timescale 1ns/1ps
`default_nettype none
module abmh_sync
  import abmh_pkg::*;
(
  input  wire logic ref_clk,
  input  wire logic nrst,
  input  wire logic async_in,
  output var  logic sync_out
);
  logic meta_r;
  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      meta_r   <= 1'b0;
      sync_out <= 1'b0;
    end
    else
    begin
      meta_r   <= async_in;
      sync_out <= meta_r;
    end
  end
endmodule // abmh_sync
`default_nettype wire

// File: abmh_handover.sv
// alternate bus master handover: request/grant, pin release, refresh
// Functional notes
// - only sdram partition zero is lent to the outside master
// - finish running memory operation and pending refresh before granting
// - never start granting while an atomic swap is in progress
// - auto-refresh before lending and after retaking, if clocks are on
// - legacy bit: mode command burst 1 before grant, burst 4 after
// - grant: cke low t, float t+1, grant t+2, cke high t+4
// - float select zero, address, oe, we, strobes, clock one, data, masks
// - direction pin floats too; outside master drives it when needed
// - request and grant both stay high for the whole lent period
// - release: cke low t, grant off t+1, drive t+3, cke high t+4
// - handover works only with pins set as output/input and mapped
// - the single clock enable governs all sdram partitions
`timescale 1ns/1ps
`default_nettype none
module abmh_handover
  import abmh_pkg::*;
(
  input  wire logic      ref_clk,
  input  wire logic      nrst,
  input  wire logic      bus_request_in,
  input  wire logic      grant_pin_is_output,
  input  wire logic      request_pin_is_input,
  input  wire logic      pins_mapped_alternate,
  input  wire logic      legacy_compat_bit,
  input  wire logic      sdram_clocks_on,
  input  wire logic      mem_op_busy,
  input  wire logic      refresh_pending,
  input  wire logic      swap_active,
  input  wire logic      cmd_done,
  output var  logic      bus_grant_out,
  output var  logic      sdram_clock_enable,
  output var  logic      sdram_pins_oe,
  output var  logic      bus_direction_oe,
  output var  logic      controller_hold,
  output var  logic [1:0] cmd_req,
  output var  logic [2:0] mode_burst_len,
  output var  logic [1:0] lent_partition
);
  ////////////////////////////////////////////////////////////////////////
  logic        req_sync;
  logic        enabled;
  abmh_state_t state_r;
  abmh_state_t state_nxt;
  logic [2:0]  tick_r;
  logic        cke_on;

  abmh_sync u_req_sync
  (
    .ref_clk  (ref_clk),
    .nrst     (nrst),
    .async_in (bus_request_in),
    .sync_out (req_sync)
  );

  assign enabled = grant_pin_is_output & request_pin_is_input &
                   pins_mapped_alternate;
  assign cke_on  = sdram_clocks_on & sdram_clock_enable;

  ////////////////////////////////////////////////////////////////////////
  // each step fires when the counter stands one below its point, so no
  // point may be zero and the steps of a sequence must keep their order
  if (GNT_TRISTATE_AT == 3'h0 || GNT_GRANT_AT <= GNT_TRISTATE_AT ||
      GNT_CKE_AT <= GNT_GRANT_AT)
  begin : g_grant_points
    $error("grant sequence points out of order");
  end
  if (REL_GRANT_AT == 3'h0 || REL_DRIVE_AT <= REL_GRANT_AT ||
      REL_CKE_AT <= REL_DRIVE_AT)
  begin : g_release_points
    $error("release sequence points out of order");
  end

  ////////////////////////////////////////////////////////////////////////
  // state sequencing; the cycle counter restarts on every state change
  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      ABMH_OWNED:
        if (req_sync && enabled)
          state_nxt = ABMH_DRAIN;
      ABMH_DRAIN:
        // a request dropped while draining simply cancels the handover
        if (!req_sync)
          state_nxt = ABMH_OWNED;
        else if (!mem_op_busy && !refresh_pending && !swap_active)
          state_nxt = cke_on ? ABMH_G_REF
                             : (legacy_compat_bit ? ABMH_G_MRS
                                                  : ABMH_G_SEQ);
      ABMH_G_REF:
        if (cmd_done)
          state_nxt = legacy_compat_bit ? ABMH_G_MRS : ABMH_G_SEQ;
      ABMH_G_MRS:
        if (cmd_done)
          state_nxt = ABMH_G_SEQ;
      ABMH_G_SEQ:
        if (tick_r == GNT_CKE_AT)
          state_nxt = ABMH_LENT;
      ABMH_LENT:
        if (!req_sync)
          state_nxt = ABMH_R_SEQ;
      ABMH_R_SEQ:
        if (tick_r == REL_CKE_AT)
          state_nxt = sdram_clocks_on ? ABMH_R_REF
                    : (legacy_compat_bit ? ABMH_R_MRS : ABMH_OWNED);
      ABMH_R_REF:
        if (cmd_done)
          state_nxt = legacy_compat_bit ? ABMH_R_MRS : ABMH_OWNED;
      ABMH_R_MRS:
        if (cmd_done)
          state_nxt = ABMH_OWNED;
      default:
        state_nxt = ABMH_OWNED;
    endcase
  end

  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
      state_r <= ABMH_OWNED;
    else
      state_r <= state_nxt;
  end

  // timing counter: t is the first cycle spent in a sequence state
  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
      tick_r <= 3'h0;
    else if (state_nxt != state_r)
      tick_r <= 3'h0;
    else if (tick_r != 3'h7)
      tick_r <= tick_r + 3'h1;
  end

  ////////////////////////////////////////////////////////////////////////
  // pin controls from flops, so each edge lands on its exact period
  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      sdram_clock_enable <= 1'b1;
      sdram_pins_oe      <= 1'b1;
      bus_direction_oe   <= 1'b1;
      bus_grant_out      <= 1'b0;
    end
    else
    begin
      // one shared enable, so every partition pauses together
      if (state_nxt == ABMH_G_SEQ && state_r != ABMH_G_SEQ)
        sdram_clock_enable <= 1'b0;
      else if (state_r == ABMH_G_SEQ && tick_r == GNT_CKE_AT - 3'h1)
        sdram_clock_enable <= 1'b1;
      else if (state_nxt == ABMH_R_SEQ && state_r != ABMH_R_SEQ)
        sdram_clock_enable <= 1'b0;
      else if (state_r == ABMH_R_SEQ && tick_r == REL_CKE_AT - 3'h1)
        sdram_clock_enable <= 1'b1;

      if (state_r == ABMH_G_SEQ && tick_r == GNT_TRISTATE_AT - 3'h1)
      begin
        sdram_pins_oe    <= 1'b0;
        bus_direction_oe <= 1'b0;
      end
      else if (state_r == ABMH_R_SEQ && tick_r == REL_DRIVE_AT - 3'h1)
      begin
        // outside master has floated by t+2, so t+3 has no contention
        sdram_pins_oe    <= 1'b1;
        bus_direction_oe <= 1'b1;
      end

      if (state_r == ABMH_G_SEQ && tick_r == GNT_GRANT_AT - 3'h1)
        bus_grant_out <= 1'b1;
      else if (state_r == ABMH_R_SEQ && tick_r == REL_GRANT_AT - 3'h1)
        bus_grant_out <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // command requests and hold toward the memory controller
  always_comb
  begin
    cmd_req        = ABMH_CMD_NONE;
    mode_burst_len = BURST_NORMAL;
    case (state_r)
      ABMH_G_REF, ABMH_R_REF:
        cmd_req = ABMH_CMD_REFRESH;
      ABMH_G_MRS:
      begin
        cmd_req        = ABMH_CMD_MODE;
        mode_burst_len = BURST_LEGACY;
      end
      ABMH_R_MRS:
        cmd_req = ABMH_CMD_MODE;
      default:
        cmd_req = ABMH_CMD_NONE;
    endcase
  end

  // hold new traffic from the draining point until the bus is back; a
  // started operation, swap or refresh must still run during the drain,
  // or the drain would wait on work that the hold itself blocks
  assign controller_hold = (state_r != ABMH_OWNED) &&
                           !(state_r == ABMH_DRAIN &&
                             (mem_op_busy || refresh_pending || swap_active));
  assign lent_partition  = SHARED_PART;

endmodule // abmh_handover
`default_nettype wire

// File: abmh_handover_properties.sv
// checker: handover pin timing seen at the block ports
`timescale 1ns/1ps
`default_nettype none
module abmh_handover_properties
  import abmh_pkg::*;
(
  input wire logic       ref_clk,
  input wire logic       nrst,
  input wire logic       bus_request_in,
  input wire logic       legacy_compat_bit,
  input wire logic       swap_active,
  input wire logic       bus_grant_out,
  input wire logic       sdram_clock_enable,
  input wire logic       sdram_pins_oe,
  input wire logic       bus_direction_oe,
  input wire logic [1:0] cmd_req,
  input wire logic [2:0] mode_burst_len,
  input wire logic [1:0] lent_partition
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  a_grant_cke_low: assert property (
    $rose(bus_grant_out) |->
    $past(sdram_clock_enable, 3) && !$past(sdram_clock_enable, 2))
    else $error("grant not two clocks after cke drop");
  a_cke_after_grant: assert property (
    $rose(bus_grant_out) |->
    !sdram_clock_enable ##1 !sdram_clock_enable ##1 sdram_clock_enable)
    else $error("cke not back at t plus four");
  a_float_then_grant: assert property (
    $fell(sdram_pins_oe) |=> $rose(bus_grant_out))
    else $error("grant not one clock after pins float");
  a_release_seq: assert property (
    $fell(bus_grant_out) |-> $past(sdram_clock_enable, 2) &&
    !sdram_clock_enable ##1 !sdram_pins_oe ##1 sdram_pins_oe
    ##1 sdram_clock_enable)
    else $error("release sequence timing wrong");
  a_dir_follows: assert property (
    bus_direction_oe == sdram_pins_oe)
    else $error("direction pin enable differs from sdram pins");
  a_request_held: assert property (
    $fell(bus_grant_out) |-> !$past(bus_request_in, 3))
    else $error("grant dropped while request high");
  a_no_grant_swap: assert property (
    $fell(sdram_clock_enable) && sdram_pins_oe |-> !$past(swap_active))
    else $error("grant sequence began during swap");
  a_mode_restore: assert property (
    $fell(bus_grant_out) && legacy_compat_bit |-> ##[3:30]
    (cmd_req == ABMH_CMD_MODE && mode_burst_len == BURST_NORMAL))
    else $error("burst length not restored after release");
  a_one_partition: assert property (
    lent_partition == SHARED_PART)
    else $error("wrong partition lent");
endmodule // abmh_handover_properties
bind abmh_handover abmh_handover_properties u_props (.ref_clk, .nrst,
  .bus_request_in, .legacy_compat_bit, .swap_active, .bus_grant_out,
  .sdram_clock_enable, .sdram_pins_oe, .bus_direction_oe, .cmd_req,
  .mode_burst_len, .lent_partition);
`default_nettype wire

// File: abmh_master_model.sv
// partner: outside bus master that borrows the sdram bus
`timescale 1ns/1ps
`default_nettype none
module abmh_master_model
(
  input  wire logic       ref_clk,
  input  wire logic       go,
  input  wire logic [7:0] hold_cyc,
  input  wire logic       bus_grant_out,
  output var  logic       bus_request_in,
  output var  logic       master_oe
);
  logic [7:0] own_cnt_r;
  initial
  begin
    bus_request_in = 1'h0;
    master_oe = 1'h0;
    own_cnt_r = 8'h00;
  end
  // short hold stays far below the refresh interval
  always @(negedge ref_clk)
  begin
    master_oe <= bus_grant_out;
    if (bus_grant_out)
    begin
      own_cnt_r <= own_cnt_r + 8'h01;
      if (own_cnt_r == hold_cyc)
        bus_request_in <= 1'h0;
    end
    else
    begin
      own_cnt_r <= 8'h00;
      bus_request_in <= go;
    end
  end
endmodule // abmh_master_model
`default_nettype wire

// File: abmh_handover_tb.sv
// testbench: handover grant, release and command order
`timescale 1ns/1ps
`default_nettype none
module abmh_handover_tb
  import abmh_pkg::*;
;
  logic       ref_clk, nrst, mapped, legacy, clk_on, busy, rpend, swap;
  logic       done, go, req, grant, cke, pins_oe, master_oe;
  logic       gpo, rpi, dir_oe, ctl_hold;
  logic [7:0] hold;
  logic [1:0] cmd, cmd_prev, lent;
  logic [2:0] burst;
  logic [4:0] q[$];
  int         n_mismatch, num_checks, cyc, i;
  abmh_handover uut (.ref_clk(ref_clk), .nrst(nrst), .bus_request_in(req),
    .grant_pin_is_output(gpo), .request_pin_is_input(rpi),
    .pins_mapped_alternate(mapped), .legacy_compat_bit(legacy),
    .sdram_clocks_on(clk_on), .mem_op_busy(busy), .refresh_pending(rpend),
    .swap_active(swap), .cmd_done(done), .bus_grant_out(grant),
    .sdram_clock_enable(cke), .sdram_pins_oe(pins_oe),
    .bus_direction_oe(dir_oe), .controller_hold(ctl_hold), .cmd_req(cmd),
    .mode_burst_len(burst), .lent_partition(lent));
  abmh_master_model partner (.ref_clk(ref_clk), .go(go), .hold_cyc(hold),
    .bus_grant_out(grant), .bus_request_in(req), .master_oe(master_oe));
  task automatic check(input logic [4:0] seen, input logic [4:0] want);
    num_checks++;
    if (seen !== want)
    begin
      n_mismatch++;
      $display("wrong value at %0t: %h expected %h", $time, seen, want);
    end
  endtask
  task automatic stop_test;
    if (n_mismatch == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial
  begin
    ref_clk = 1'h0;
    forever #25 ref_clk = ~ref_clk;
  end
  // controller side: finish a command one clock after it appears, or two when it directly follows another
  always @(negedge ref_clk)
    done <= (cmd != ABMH_CMD_NONE) && !done;
  always @(negedge ref_clk)
  begin
    cyc++;
    if (cmd !== cmd_prev && cmd != ABMH_CMD_NONE)
      check({cmd, cmd[1] ? burst : 3'h0}, q.pop_front());
    check({4'h0, master_oe & pins_oe}, 5'h00);
    check({4'h0, master_oe & dir_oe}, 5'h00);
    if (grant)
      check({4'h0, ctl_hold}, 5'h01);
    cmd_prev <= cmd;
    if (cyc == 3000)
    begin
      n_mismatch++;
      stop_test();
    end
  end
  initial
  begin
    {nrst, gpo, rpi, mapped, legacy, clk_on, busy, rpend, swap} = '0;
    go <= 1'h0;
    hold = 8'h00;
    void'($urandom(49862));
    repeat (16) @(negedge ref_clk);
    nrst = 1'h1;
    // each enable missing in turn: the request must be refused
    for (i = 0; i < 3; i++)
    begin
      {gpo, rpi, mapped} = ~(3'h1 << i);
      go <= 1'h1;
      repeat (20) @(negedge ref_clk);
      check({3'h0, grant, ctl_hold}, 5'h00);
      go <= 1'h0;
      repeat (4) @(negedge ref_clk);
    end
    check({3'h0, lent}, {3'h0, SHARED_PART});
    {gpo, rpi, mapped} = 3'h7;
    for (i = 0; i < 8; i++)
    begin
      legacy = i[0];
      clk_on = i[1];
      hold = 8'($urandom_range(40, 1));
      if (clk_on) q.push_back({ABMH_CMD_REFRESH, 3'h0});
      if (legacy) q.push_back({ABMH_CMD_MODE, BURST_LEGACY});
      if (clk_on) q.push_back({ABMH_CMD_REFRESH, 3'h0});
      if (legacy) q.push_back({ABMH_CMD_MODE, BURST_NORMAL});
      // raise swap in the last four passes and random busy/refresh-pending bits, so granting waits while any is set
      {swap, busy, rpend} = {i[2], 2'($urandom)};
      go <= 1'h1;
      repeat ($urandom_range(8, 1)) @(negedge ref_clk);
      {swap, busy, rpend} = 3'h0;
      while (!grant) @(negedge ref_clk);
      go <= 1'h0;
      while (grant) @(negedge ref_clk);
      repeat (30) @(negedge ref_clk);
      check(5'(q.size()), 5'h00);
    end
    stop_test();
  end
endmodule // abmh_handover_tb
`default_nettype wire
